// ### rtl/system_clock_mode_control.sv
// Purpose: Clock source and divider select, fast oscillator control, power-down modes.
// Assumes: Halt and wake come from the core; oscillator inputs are asynchronous.
// Notes: The divided clock is produced as a one-cycle enable every 2^code high-speed ticks, or per sub clock tick.
// ----------------------------------------------------------------
// How it works
// - Select code picks fH divide or sub clock.
// - Halt high enable keeps fast oscillator running.
// - Halt low enable keeps slow oscillator running.
// - Unused register bits ignore writes, read zero.
// - Clock switch settles after four current periods.
// - Frequency field selects 2, 4, 8 MHz.
// - New frequency applies once stable flag sets.
// - Enabling oscillator clears stable flag, then sets.
// - Oscillator enable bit starts oscillator; stops it only with sub clock selected.
// - Halt enable bits choose sleep or idle mode.
// - Code 111 in fast mode enters slow mode.
// - Slow mode waits for stable low-speed oscillator.
// - Leaving slow restarts fast oscillator if stopped.
// - Sleep stops all clocks except watchdog.
// - Idle low-only stops fast clock, keeps sub.
// - Idle both keeps both clocks running.
// - Idle high-only keeps fast, stops sub clock unless watchdog.
// - Power-down keeps registers and ports unchanged.
// - Power-down sets down flag, clears timeout flag.
// - Power-down clears the watchdog counter.
// - Sleep keeps slow oscillator only with watchdog.
// ----------------------------------------------------------------
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
module system_clock_mode_control
  import clk_mode_pkg::*;
#(
  parameter int div_width = 6
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core events.
  input wire logic halt_pulse,
  input wire logic wake_pulse,
  input wire logic watchdog_enabled,
  // Oscillator status from the analog side.
  input wire logic hs_ready_pin,
  input wire logic ls_ready_pin,
  input wire logic hs_tick,
  input wire logic ls_tick,
  // Clock control outputs.
  output clk_gate_s gates,
  output logic [1:0] hs_freq_applied,
  output logic sys_clk_en,
  output logic [2:0] op_mode,
  output pd_event_s pd_event
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The divider must reach divide by 64.
  if (div_width < 6) begin : g_bad_div
    $error("div_width must be at least 6");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0] clock_select_field; // Requested source code.
  logic halt_high_speed_enable; // Keep fast oscillator in halt.
  logic halt_low_speed_enable; // Keep slow oscillator in halt.
  logic [1:0] hs_frequency_field; // Requested frequency.
  logic hs_oscillator_enable; // Fast oscillator software enable.
  logic hs_stable_flag; // Fast oscillator stable.
  logic hs_sync1, hs_sync2; // Stable synchroniser.
  logic ls_sync1, ls_sync2; // Low-speed stable synchroniser.
  logic hs_tick1, hs_tick2, hs_tick3; // Fast tick synchroniser and edge.
  logic ls_tick1, ls_tick2, ls_tick3; // Slow tick synchroniser and edge.
  logic [2:0] active_select; // Source code in use.
  logic [2:0] switch_cnt; // Current-clock periods counted during a switch.
  logic switching; // A switch is pending.
  logic [div_width-1:0] div_cnt; // Fast clock divider.
  op_mode_e mode; // Current operating mode.
  logic hs_fast_edge, ls_edge; // One-cycle tick enables.
  logic [div_width-1:0] div_mask; // Low divider bits that must all be one.
  logic halt_taken; // Halt accepted while the core runs.
  logic target_ready; // Target source can be used.
  logic aw_seen, w_seen; // Write channel capture flags.
  logic [3:0] aw_addr; // Captured write address.
  logic [31:0] w_data; // Captured write data.
  logic [3:0] w_strb; // Captured strobes.
  logic hs_restart; // Enable or frequency change needs a fresh stable.
  logic next_sys_clk_en; // Next value of the system clock enable.

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Asynchronous oscillator signals pass two flops before use.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {hs_sync1, hs_sync2, ls_sync1, ls_sync2} <= '0;
      {hs_tick1, hs_tick2, hs_tick3, ls_tick1, ls_tick2, ls_tick3} <= '0;
    end else begin
      {hs_sync2, hs_sync1} <= {hs_sync1, hs_ready_pin};
      {ls_sync2, ls_sync1} <= {ls_sync1, ls_ready_pin};
      {hs_tick3, hs_tick2, hs_tick1} <= {hs_tick2, hs_tick1, hs_tick};
      {ls_tick3, ls_tick2, ls_tick1} <= {ls_tick2, ls_tick1, ls_tick};
    end
  end

  // Rising edges of the synchronised ticks are the clock enables.
  assign hs_fast_edge = hs_tick2 & ~hs_tick3 & gates.hs_run;
  assign ls_edge = ls_tick2 & ~ls_tick3 & gates.ls_run;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  // Write address and data are taken independently; response after both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_seen <= 1'b0;
      w_seen <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      // Ready is offered while the matching half is not held.
      s_axi_awready <= !aw_seen && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_seen && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_seen <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_seen <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_seen && w_seen) begin
        // Both halves present: commit and answer.
        aw_seen <= 1'b0;
        w_seen <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == off_system_clock_select ||
                        aw_addr == off_hs_oscillator_control ||
                        aw_addr == off_mode_status) ? resp_okay : resp_slverr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; only lane 0 carries bits, the rest are ignored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_select_field <= sel_reset;
      halt_high_speed_enable <= 1'b0;
      halt_low_speed_enable <= 1'b0;
      hs_frequency_field <= freq_reset;
      hs_oscillator_enable <= osc_en_reset;
    end else if (aw_seen && w_seen && w_strb[0]) begin
      if (aw_addr == off_system_clock_select) begin
        clock_select_field <= w_data[sel_pos +: 3];
        halt_high_speed_enable <= w_data[halt_hs_pos];
        halt_low_speed_enable <= w_data[halt_ls_pos];
      end else if (aw_addr == off_hs_oscillator_control) begin
        hs_frequency_field <= w_data[freq_pos +: 2];
        hs_oscillator_enable <= w_data[osc_en_pos];
      end
    end
  end

  // Read channel; unused bits are zero and unmapped addresses error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= resp_okay;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= resp_okay;
        s_axi_rdata <= 32'h0;
        unique case (s_axi_araddr)
          off_system_clock_select: begin
            s_axi_rdata[sel_pos +: 3] <= clock_select_field;
            s_axi_rdata[halt_hs_pos] <= halt_high_speed_enable;
            s_axi_rdata[halt_ls_pos] <= halt_low_speed_enable;
          end
          off_hs_oscillator_control: begin
            s_axi_rdata[freq_pos +: 2] <= hs_frequency_field;
            s_axi_rdata[stable_pos] <= hs_stable_flag;
            s_axi_rdata[osc_en_pos] <= hs_oscillator_enable;
          end
          off_mode_status: begin
            s_axi_rdata[2:0] <= mode;
            s_axi_rdata[3] <= switching;
            s_axi_rdata[6:4] <= active_select;
          end
          default: s_axi_rresp <= resp_slverr;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // High-speed oscillator stability and frequency
  // ----------------------------------------------------------------
  // An enable from 0 or a new frequency restarts the stability wait.
  assign hs_restart = aw_seen && w_seen && w_strb[0] && aw_addr == off_hs_oscillator_control &&
                      ((w_data[osc_en_pos] && !hs_oscillator_enable) ||
                       w_data[freq_pos +: 2] != hs_frequency_field);

  // Stable flag clears on restart and sets from the synchronised input.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_stable_flag <= 1'b0;
    end else if (hs_restart || !gates.hs_run) begin
      hs_stable_flag <= 1'b0;
    end else if (hs_sync2) begin
      hs_stable_flag <= 1'b1;
    end
  end

  // The applied frequency follows the field only once stable.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_freq_applied <= freq_2mhz;
    end else if (hs_stable_flag) begin
      // Code 3 maps back to 2 MHz.
      hs_freq_applied <= (hs_frequency_field == freq_8mhz) ? freq_8mhz :
                         (hs_frequency_field == freq_4mhz) ? freq_4mhz : freq_2mhz;
    end
  end

  // ----------------------------------------------------------------
  // Source switch and divider
  // ----------------------------------------------------------------
  // Target is usable: fast source needs stable fast, slow needs stable slow.
  assign target_ready = (clock_select_field == sel_sub) ? ls_sync2 : hs_stable_flag;

  // Count four current clock periods, then wait for the target to be ready.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_select <= sel_reset;
      switch_cnt <= 3'h0;
      switching <= 1'b0;
    end else if (clock_select_field != active_select) begin
      switching <= 1'b1;
      if (switch_cnt < 3'(switch_sys_periods)) begin
        if (sys_clk_en || !gates.sys_run) begin
          switch_cnt <= switch_cnt + 3'h1;
        end
      end else if (target_ready) begin
        active_select <= clock_select_field;
        switch_cnt <= 3'h0;
      end
    end else begin
      switching <= 1'b0;
      switch_cnt <= 3'h0;
    end
  end

  // Divider on fast ticks.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= '0;
    end else if (hs_fast_edge) begin
      div_cnt <= div_cnt + div_width'(1);
    end
  end

  // One pulse per 2^code fast ticks: the low code bits of the divider are all one.
  assign div_mask = (div_width'(1) << active_select) - div_width'(1);

  // Enable pulses at fH / 2^code or at the sub clock tick; none while the clock is gated.
  always_comb begin
    if (!gates.sys_run) begin
      next_sys_clk_en = 1'b0;
    end else if (active_select == sel_sub) begin
      next_sys_clk_en = ls_edge;
    end else begin
      next_sys_clk_en = hs_fast_edge && ((div_cnt & div_mask) == div_mask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_clk_en <= 1'b0;
    end else begin
      sys_clk_en <= next_sys_clk_en;
    end
  end

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  // Halt picks the power-down mode; wake returns to fast or slow.
  // Registers and ports are untouched by mode changes.
  assign halt_taken = halt_pulse && (mode == mode_fast || mode == mode_slow);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= mode_fast;
    end else if (halt_taken) begin
      unique case ({halt_high_speed_enable, halt_low_speed_enable})
        2'b00: mode <= mode_sleep;
        2'b01: mode <= mode_idle_low_only;
        2'b11: mode <= mode_idle_both_clocks;
        2'b10: mode <= mode_idle_high_only;
      endcase
    end else if (wake_pulse && mode != mode_fast && mode != mode_slow) begin
      mode <= (active_select == sel_sub) ? mode_slow : mode_fast;
    end else if (mode == mode_fast || mode == mode_slow) begin
      mode <= (active_select == sel_sub) ? mode_slow : mode_fast;
    end
  end

  // Gates per mode, and the mode shown to the rest of the chip one cycle on.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gates <= '{hs_run: 1'b1, ls_run: 1'b1, sys_run: 1'b1, cpu_run: 1'b1};
      op_mode <= mode_fast;
    end else begin
      op_mode <= mode;
      unique case (mode)
        mode_fast, mode_slow: begin
          // Fast oscillator runs when enabled or needed by the source.
          gates.hs_run <= hs_oscillator_enable || clock_select_field != sel_sub;
          gates.ls_run <= 1'b1;
          gates.sys_run <= 1'b1;
          gates.cpu_run <= 1'b1;
        end
        mode_sleep: begin
          gates.hs_run <= 1'b0;
          gates.ls_run <= watchdog_enabled;
          gates.sys_run <= 1'b0;
          gates.cpu_run <= 1'b0;
        end
        mode_idle_low_only: begin
          gates.hs_run <= 1'b0;
          gates.ls_run <= 1'b1;
          gates.sys_run <= active_select == sel_sub;
          gates.cpu_run <= 1'b0;
        end
        mode_idle_both_clocks: begin
          gates.hs_run <= 1'b1;
          gates.ls_run <= 1'b1;
          gates.sys_run <= 1'b1;
          gates.cpu_run <= 1'b0;
        end
        mode_idle_high_only: begin
          gates.hs_run <= 1'b1;
          gates.ls_run <= watchdog_enabled;
          gates.sys_run <= active_select != sel_sub;
          gates.cpu_run <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power-down events
  // ----------------------------------------------------------------
  // One pulse per entry into any power-down mode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_event <= '0;
    end else begin
      pd_event <= {3{halt_taken}};
    end
  end

endmodule

// ### common/clk_mode_pkg.sv
// Purpose: Shared constants and types for the system clock and power mode controller.
// Assumes: One 40 MHz bus clock; registers reached over AXI4-Lite with 32-bit data.
// Notes: Offsets are byte addresses of aligned words.
package clk_mode_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] off_system_clock_select = 4'h0;
  localparam logic [3:0] off_hs_oscillator_control = 4'h4;
  localparam logic [3:0] off_mode_status = 4'h8;

  // Field positions in the system clock select register.
  localparam int sel_pos = 5;
  localparam int halt_hs_pos = 1;
  localparam int halt_ls_pos = 0;
  // Field positions in the oscillator control register.
  localparam int freq_pos = 2;
  localparam int stable_pos = 1;
  localparam int osc_en_pos = 0;

  // Reset values.
  localparam logic [2:0] sel_reset = 3'h0;
  localparam logic [1:0] freq_reset = 2'h0;
  localparam logic osc_en_reset = 1'b1;

  // Clock select code for the low-speed sub clock.
  localparam logic [2:0] sel_sub = 3'h7;

  // Frequency codes.
  localparam logic [1:0] freq_2mhz = 2'h0;
  localparam logic [1:0] freq_4mhz = 2'h1;
  localparam logic [1:0] freq_8mhz = 2'h2;

  // Switch delay: four current system clock periods before the switch.
  localparam int switch_sys_periods = 4;

  // AXI responses.
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // Operating modes.
  typedef enum logic [2:0] {
    mode_fast, mode_slow, mode_sleep, mode_idle_low_only, mode_idle_both_clocks,
    mode_idle_high_only
  } op_mode_e;

  // Oscillator enables and clock gates seen by the clock tree.
  typedef struct packed {
    logic hs_run;
    logic ls_run;
    logic sys_run;
    logic cpu_run;
  } clk_gate_s;

  // Power-down side effects toward the status and watchdog logic.
  typedef struct packed {
    logic set_power_down_flag;
    logic clear_watchdog_timeout_flag;
    logic clear_watchdog_counter;
  } pd_event_s;

endpackage

// ### bench/clk_mode_checker.sv
// Purpose: Concurrent checks on the clock and power mode controller outputs.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Attached to the top module by the bind below the module.
module clk_mode_checker
  import clk_mode_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Watched ports.
  input wire logic halt_pulse,
  input wire logic watchdog_enabled,
  input wire clk_gate_s gates,
  input wire logic [1:0] hs_freq_applied,
  input wire logic sys_clk_en,
  input wire logic [2:0] op_mode,
  input wire pd_event_s pd_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // High while the core executes, so a halt is accepted.
  wire logic run = (op_mode == mode_fast) || (op_mode == mode_slow);
  // A halt in a run mode gives all three side-effect pulses one edge later.
  property p_halt_ev;
    halt_pulse && run |=> pd_event == 3'h7;
  endproperty
  a_halt_ev: assert property (p_halt_ev) else $error("halt gave no power-down pulses");
  property p_pd_once;
    pd_event.clear_watchdog_counter |=> !pd_event.clear_watchdog_counter;
  endproperty
  a_pd_once: assert property (p_pd_once) else $error("counter clear pulse too long");
  property p_enter;
    halt_pulse && run |-> ##2 !run;
  endproperty
  a_enter: assert property (p_enter) else $error("halt did not enter power-down");
  // Gate checks wait a cycle after a mode change so registered gates settle.
  property p_sleep;
    op_mode == mode_sleep && $stable(op_mode) |-> !gates.hs_run && !gates.sys_run
      && !gates.cpu_run && !sys_clk_en;
  endproperty
  a_sleep: assert property (p_sleep) else $error("clock running in sleep");
  property p_sleep_ls;
    op_mode == mode_sleep && $stable(op_mode) && $stable(watchdog_enabled)
      |-> gates.ls_run == watchdog_enabled;
  endproperty
  a_sleep_ls: assert property (p_sleep_ls) else $error("slow osc wrong in sleep");
  property p_idle_lo;
    op_mode == mode_idle_low_only && $stable(op_mode) |-> !gates.hs_run && gates.ls_run
      && !gates.cpu_run;
  endproperty
  a_idle_lo: assert property (p_idle_lo) else $error("idle low-only gates wrong");
  property p_idle_both;
    op_mode == mode_idle_both_clocks && $stable(op_mode) |-> gates.hs_run && gates.ls_run
      && !gates.cpu_run;
  endproperty
  a_idle_both: assert property (p_idle_both) else $error("idle both gates wrong");
  property p_idle_hi;
    op_mode == mode_idle_high_only && $stable(op_mode) |-> gates.hs_run && !gates.cpu_run;
  endproperty
  a_idle_hi: assert property (p_idle_hi) else $error("idle high-only gates wrong");
  property p_freq;
    hs_freq_applied != 2'h3;
  endproperty
  a_freq: assert property (p_freq) else $error("illegal applied frequency");
  property p_reset;
    $rose(aresetn) |-> op_mode == mode_fast && gates.cpu_run && hs_freq_applied == freq_2mhz;
  endproperty
  a_reset: assert property (p_reset) else $error("wrong state after reset");
endmodule

bind system_clock_mode_control clk_mode_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .halt_pulse(halt_pulse), .watchdog_enabled(watchdog_enabled), .gates(gates),
  .hs_freq_applied(hs_freq_applied), .sys_clk_en(sys_clk_en), .op_mode(op_mode),
  .pd_event(pd_event));

// ### bench/testbench.sv
// Purpose: Register, clock select and power mode tests over AXI4-Lite.
// Assumes: 40 MHz aclk; oscillator ticks and ready levels are made here.
// Notes: The fast tick has a period of 8 aclk, the slow tick 64 aclk.
module testbench
  import clk_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, hs_freq_applied, r;
  logic halt_pulse = 1'b0, wake_pulse = 1'b0, watchdog_enabled = 1'b0;
  logic hs_ready_pin = 1'b1, ls_ready_pin = 1'b1, hs_tick = 1'b0, ls_tick = 1'b0;
  clk_gate_s gates;
  pd_event_s pd_event;
  logic sys_clk_en;
  logic [2:0] op_mode;
  logic [5:0] tick_cnt = 6'h0;
  logic [31:0] d;
  int err_total = 0;
  int cmp_count = 0;
  int c;
  // Halt bits, watchdog, expected mode and expected {hs_run, ls_run, cpu_run}.
  logic [1:0] hb_t [5] = '{2'h0, 2'h0, 2'h1, 2'h3, 2'h2};
  logic wd_t [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  logic [2:0] md_t [5] = '{mode_sleep, mode_sleep, mode_idle_low_only,
    mode_idle_both_clocks, mode_idle_high_only};
  logic [2:0] gt_t [5] = '{3'h0, 3'h2, 3'h2, 3'h6, 3'h4};
  logic [1:0] fc_t [3] = '{2'h2, 2'h1, 2'h3};
  logic [1:0] fe_t [3] = '{2'h2, 2'h1, 2'h0};
  system_clock_mode_control #(.div_width(6)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .halt_pulse(halt_pulse),
    .wake_pulse(wake_pulse), .watchdog_enabled(watchdog_enabled), .hs_ready_pin(hs_ready_pin),
    .ls_ready_pin(ls_ready_pin), .hs_tick(hs_tick), .ls_tick(ls_tick), .gates(gates),
    .hs_freq_applied(hs_freq_applied), .sys_clk_en(sys_clk_en), .op_mode(op_mode),
    .pd_event(pd_event));
  // ----------------------------------------------------------------
  // Clocks and tasks
  // ----------------------------------------------------------------
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  // Free-running oscillator ticks, both slower than a quarter of aclk.
  always @(posedge aclk) begin
    tick_cnt <= tick_cnt + 6'h1;
    hs_tick <= tick_cnt[2];
    ls_tick <= tick_cnt[5];
  end
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write one word; each valid drops at the edge that took it; only the watchdog ends a wait.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_mode(input logic [2:0] m);
    while (op_mode !== m) @(posedge aclk);
  endtask
  // Counts system clock enables over a window.
  task automatic count_en(input int cyc, output int k);
    k = 0;
    repeat (cyc) begin
      @(posedge aclk);
      if (sys_clk_en === 1'b1) k++;
    end
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(4'h0, d, r);
    check(d, 32'h0);
    axi_rd(4'h4, d, r);
    check(d & 32'hfffffffd, 32'h1);
    axi_wr(4'h0, 32'hffffff1f, r);
    axi_rd(4'h0, d, r);
    check(d, 32'h3);
    axi_wr(4'h4, 32'hfffffff1, r);
    axi_rd(4'h4, d, r);
    check(d & 32'hfffffffd, 32'h1);
    axi_wr(4'hc, 32'h1, r);
    check(32'(r), 32'(resp_slverr));
    axi_rd(4'hc, d, r);
    check(d, 32'h0);
    // Each halt bit setting, sleep with and without the watchdog.
    for (int i = 0; i < 5; i++) begin
      watchdog_enabled <= wd_t[i];
      axi_wr(4'h0, 32'(hb_t[i]), r);
      halt_pulse <= 1'b1;
      @(posedge aclk);
      halt_pulse <= 1'b0;
      @(posedge aclk);
      check(32'(pd_event), 32'h7);
      repeat (3) @(posedge aclk);
      check(32'(op_mode), 32'(md_t[i]));
      check({gates.hs_run, gates.ls_run, gates.cpu_run}, 32'(gt_t[i]));
      wake_pulse <= 1'b1;
      @(posedge aclk);
      wake_pulse <= 1'b0;
      wait_mode(mode_fast);
      axi_rd(4'h0, d, r);
      check(d, 32'(hb_t[i]));
    end
    // Divider codes; the wait covers four periods of the previous code.
    for (int k = 0; k < 7; k++) begin
      axi_wr(4'h0, 32'(k) << 5, r);
      repeat ((32 << k) + 200) @(posedge aclk);
      count_en(1024, c);
      check(32'(c >= (128 >> k) - 1 && c <= (128 >> k) + 1), 32'h1);
    end
    ls_ready_pin <= 1'b0;
    axi_wr(4'h0, 32'he0, r);
    repeat (2600) @(posedge aclk);
    check(32'(op_mode), 32'(mode_fast));
    ls_ready_pin <= 1'b1;
    wait_mode(mode_slow);
    check(32'(op_mode), 32'(mode_slow));
    count_en(640, c);
    check(32'(c >= 9 && c <= 11), 32'h1);
    hs_ready_pin <= 1'b0;
    axi_wr(4'h4, 32'h0, r);
    repeat (10) @(posedge aclk);
    check(32'(gates.hs_run), 32'h0);
    axi_rd(4'h4, d, r);
    check(d, 32'h0);
    axi_wr(4'h0, 32'h0, r);
    repeat (600) @(posedge aclk);
    check({gates.hs_run, op_mode}, {1'b1, mode_slow});
    hs_ready_pin <= 1'b1;
    wait_mode(mode_fast);
    check(32'(op_mode), 32'(mode_fast));
    hs_ready_pin <= 1'b0;
    axi_wr(4'h4, 32'h9, r);
    repeat (20) @(posedge aclk);
    check(32'(hs_freq_applied), 32'(freq_2mhz));
    axi_rd(4'h4, d, r);
    check(d, 32'h9);
    hs_ready_pin <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      axi_wr(4'h4, {28'h0, fc_t[i], 2'h1}, r);
      c = 0;
      while (hs_freq_applied !== fe_t[i] && c < 200) begin
        @(posedge aclk);
        c++;
      end
      check(32'(hs_freq_applied), 32'(fe_t[i]));
    end
    tally_and_finish();
  end
  // Cuts a hang short well after the expected run length.
  initial begin
    repeat (40000) @(posedge aclk);
    err_total++;
    tally_and_finish();
  end
endmodule
